// file: logic/dwsp_pkg.sv
// Purpose: shared constants and types for the dynamic width serial slave port
// Assumes: 4 bidirectional data lines, two byte buffers facing the usb side
// Notes: command byte positions are lsb first as sampled on the link
package dwsp_pkg;
   localparam int BUF_BYTES = 512;
   localparam int BYTE_W = 8;
   localparam int LANES = 4;
   localparam int SYNC_BITS = 8;

   // command codes
   localparam logic [3:0] CMD_WRITE = 4'h0;
   localparam logic [3:0] CMD_READ = 4'h1;
   localparam logic [3:0] CMD_RD_MODEM = 4'h2;
   localparam logic [3:0] CMD_WR_MODEM = 4'h3;
   localparam logic [3:0] CMD_FLUSH = 4'h4;
   localparam logic [3:0] CMD_MEM_ADDR = 4'h5;
   localparam logic [3:0] CMD_MEM_WR = 4'h6;
   localparam logic [3:0] CMD_MEM_RD = 4'h7;
   localparam logic [3:0] CMD_USB_STATE = 4'h8;

   // command byte field positions
   localparam int POS_CMD3 = 0;
   localparam int POS_WIDTH_FLAG2 = 1;
   localparam int POS_WIDTH_FLAG4 = 2;
   localparam int POS_CMD2 = 3;
   localparam int POS_WIDTH_FLAG8 = 4;
   localparam int POS_CMD1 = 5;
   localparam int POS_CMD0 = 6;

   // reset values, and the all-released enable for the command and write phases
   localparam logic [3:0] DOUT_RST = 4'h1;
   localparam logic [3:0] OE_N_IDLE = 4'hE;
   localparam logic [3:0] OE_N_OFF = 4'hF;
   localparam logic [7:0] SYNC_RST = 8'h6F;
   localparam logic [7:0] BYTE_RST = 8'h00;

   typedef enum logic [1:0] {
      WID_1 = 2'b00,
      WID_2 = 2'b01,
      WID_4 = 2'b10
   } dwsp_width_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CMD = 2'b01,
      ST_DATA = 2'b10
   } dwsp_state_type;
endpackage : dwsp_pkg

// file: logic/dwsp_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: each bit is an independent level
// Notes: the first stage feeds only the second
`timescale 1ns/1ps
module dwsp_sync #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;

   if (WIDTH < 1) begin : g_bad_width
      $error("dwsp_sync: WIDTH must be at least 1");
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         meta_r <= RESET_VAL;
         sync_r <= RESET_VAL;
      end else begin
         meta_r <= i_async;
         sync_r <= meta_r;
      end
   end

   assign o_sync = sync_r;
endmodule : dwsp_sync

// file: logic/dwsp_fifo.sv
// Purpose: byte buffer with registered head word and valid/ready on both sides
// Assumes: depth is a power of two
// Notes: head register shows the oldest word, written words bypass into it when empty
`timescale 1ns/1ps
module dwsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 512
) (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_clear,
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire logic [WIDTH-1:0] i_wr_data,
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output logic [WIDTH-1:0] o_rd_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
   logic [AW:0] count_r, count_nxt;
   logic [WIDTH-1:0] head_r, head_nxt;
   logic wr_en, rd_en;

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("dwsp_fifo: DEPTH must be a power of two of at least 2");
   end

   assign o_wr_ready = count_r != FULL_COUNT;
   assign o_rd_valid = count_r != '0;
   assign wr_en = i_wr_valid && o_wr_ready;
   assign rd_en = o_rd_valid && i_rd_ready;
   assign o_rd_data = head_r;

   always_comb begin
      wr_ptr_nxt = wr_ptr_r + AW'(wr_en);
      rd_ptr_nxt = rd_ptr_r + AW'(rd_en);
      count_nxt = count_r + (AW + 1)'(wr_en) - (AW + 1)'(rd_en);
      // bypass keeps the head correct when the new word lands at the head slot
      head_nxt = (wr_en && wr_ptr_r == rd_ptr_nxt) ? i_wr_data : mem[rd_ptr_nxt];
      if (i_clear) begin
         wr_ptr_nxt = '0;
         rd_ptr_nxt = '0;
         count_nxt = '0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (wr_en) begin
         mem[wr_ptr_r] <= i_wr_data;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
         head_r <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r <= count_nxt;
         head_r <= head_nxt;
      end
   end
endmodule : dwsp_fifo

// file: logic/dwsp_port.sv
// Purpose: slave end of a select framed link of dynamic width 1, 2 or 4 lines
// Assumes: link clock, select and data pins are sampled by i_clk_sys (far faster)
// Notes: the pad pull-ups sit outside; undriven lines arrive here as one
`timescale 1ns/1ps
// Summary of operation
// - deselected: space on line 0, data-available on miso
// - two 512-byte buffers with space/available flags
// - command and width phase, then data phase
// - ack or nak on miso every data byte
// - width rides with command on first sample
// - line 3 or 2 low selects four lines
// - line 1 low selects two, else one
// - pulled-up lines read as one
// - remaining command bits give a 4-bit command
// - fixed command byte bit layout
// - bits per clock equal width; eight beats at one
// - widths up to four lines only
// - usb bytes buffered then sent over link
// - link bytes buffered then drained by usb
// - buffer logic runs on the reference clock
// - power-on reset plus external active-low reset
// - command code values, nine defined; write, read and flush implemented
// - drive on leading edges, sample on trailing edges
// - clock idle level follows polarity setting
module dwsp_port #(
   parameter int BUF_DEPTH = dwsp_pkg::BUF_BYTES
) (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_reset_ext_n,
   input wire logic i_cpol,
   input wire logic i_link_clk,
   input wire logic i_select_n,
   input wire logic [3:0] i_data_in,
   output logic [3:0] o_data_out,
   output logic [3:0] o_data_oe_n,
   output logic o_miso,
   input wire logic [7:0] i_usb_rx_data,
   input wire logic i_usb_rx_valid,
   output logic o_usb_rx_ready,
   output logic [7:0] o_usb_tx_data,
   output logic o_usb_tx_valid,
   input wire logic i_usb_tx_ready,
   output logic o_flush_pulse
);
   if (BUF_DEPTH < 2) begin : g_bad_depth
      $error("dwsp_port: BUF_DEPTH too small");
   end

   function automatic dwsp_pkg::dwsp_width_type decode_width(input logic [3:0] lines);
      dwsp_pkg::dwsp_width_type w;
      w = dwsp_pkg::WID_1;
      if (lines[3:2] != 2'b11) begin
         w = dwsp_pkg::WID_4;
      end else if (!lines[1]) begin
         w = dwsp_pkg::WID_2;
      end
      return w;
   endfunction : decode_width

   function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic [3:0] lines,
                                           input dwsp_pkg::dwsp_width_type w);
      logic [7:0] r;
      unique case (w)
         dwsp_pkg::WID_4: r = {lines, sr[7:4]};
         dwsp_pkg::WID_2: r = {lines[1:0], sr[7:2]};
         default: r = {lines[0], sr[7:1]};
      endcase
      return r;
   endfunction : shift_in

   function automatic logic [7:0] shift_out(input logic [7:0] sr,
                                            input dwsp_pkg::dwsp_width_type w);
      logic [7:0] r;
      unique case (w)
         dwsp_pkg::WID_4: r = {4'h0, sr[7:4]};
         dwsp_pkg::WID_2: r = {2'h0, sr[7:2]};
         default: r = {1'b0, sr[7:1]};
      endcase
      return r;
   endfunction : shift_out

   // beats of one byte at width w
   function automatic logic [3:0] byte_beats(input dwsp_pkg::dwsp_width_type w);
      logic [3:0] n;
      unique case (w)
         dwsp_pkg::WID_4: n = 4'h2;
         dwsp_pkg::WID_2: n = 4'h4;
         default: n = 4'h8;
      endcase
      return n;
   endfunction : byte_beats

   function automatic logic [3:0] lane_mask(input dwsp_pkg::dwsp_width_type w);
      logic [3:0] m;
      unique case (w)
         dwsp_pkg::WID_4: m = 4'hF;
         dwsp_pkg::WID_2: m = 4'h3;
         default: m = 4'h1;
      endcase
      return m;
   endfunction : lane_mask

   // pin synchronisers
   logic [7:0] pins_s;
   logic cpol_s, ext_n_s, sel_n_s, clk_s;
   logic [3:0] lines_s;

   dwsp_sync #(
      .WIDTH(dwsp_pkg::SYNC_BITS),
      .RESET_VAL(dwsp_pkg::SYNC_RST)
   ) u_sync (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_async({i_cpol, i_reset_ext_n, i_select_n, i_link_clk, i_data_in}),
      .o_sync(pins_s)
   );

   assign {cpol_s, ext_n_s, sel_n_s, clk_s, lines_s} = pins_s;

   // edge finder on the sampled link clock
   logic clk_d_r;
   logic lead, trail, ext_clear;

   assign lead = (clk_s != clk_d_r) && (clk_d_r == cpol_s);
   assign trail = (clk_s != clk_d_r) && (clk_s == cpol_s);
   assign ext_clear = !ext_n_s;

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         clk_d_r <= 1'b0;
      end else begin
         clk_d_r <= clk_s;
      end
   end

   // buffers facing the usb side
   logic rx_valid, rx_pop, tx_space, tx_push;
   logic [7:0] rx_data, in_byte;

   dwsp_fifo #(
      .WIDTH(dwsp_pkg::BYTE_W),
      .DEPTH(BUF_DEPTH)
   ) u_rx_buf (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_clear(ext_clear),
      .i_wr_valid(i_usb_rx_valid),
      .o_wr_ready(o_usb_rx_ready),
      .i_wr_data(i_usb_rx_data),
      .o_rd_valid(rx_valid),
      .i_rd_ready(rx_pop),
      .o_rd_data(rx_data)
   );

   dwsp_fifo #(
      .WIDTH(dwsp_pkg::BYTE_W),
      .DEPTH(BUF_DEPTH)
   ) u_tx_buf (
      .i_clk_sys(i_clk_sys),
      .i_reset(i_reset),
      .i_clear(ext_clear),
      .i_wr_valid(tx_push),
      .o_wr_ready(tx_space),
      .i_wr_data(in_byte),
      .o_rd_valid(o_usb_tx_valid),
      .i_rd_ready(i_usb_tx_ready),
      .o_rd_data(o_usb_tx_data)
   );

   // link state
   dwsp_pkg::dwsp_state_type state_r, state_nxt;
   dwsp_pkg::dwsp_width_type width_r, width_nxt;
   logic [3:0] cmd_r, cmd_nxt, beat_r, beat_nxt, cmd_field, half_beats;
   logic [7:0] sr_in_r, sr_in_nxt, sr_out_r, sr_out_nxt;
   logic first_r, first_nxt, ack_r, ack_nxt, flush_r, flush_nxt;

   assign in_byte = shift_in(sr_in_r, lines_s, width_r);
   // the flag at bit 4 is ignored: no eight-line width here
   assign cmd_field = {in_byte[dwsp_pkg::POS_CMD3], in_byte[dwsp_pkg::POS_CMD2],
                       in_byte[dwsp_pkg::POS_CMD1], in_byte[dwsp_pkg::POS_CMD0]};
   assign half_beats = byte_beats(width_r) >> 1;

   always_comb begin
      state_nxt = state_r;
      width_nxt = width_r;
      cmd_nxt = cmd_r;
      sr_in_nxt = sr_in_r;
      sr_out_nxt = sr_out_r;
      beat_nxt = beat_r;
      first_nxt = first_r;
      ack_nxt = ack_r;
      flush_nxt = 1'b0;
      rx_pop = 1'b0;
      tx_push = 1'b0;
      unique case (state_r)
         dwsp_pkg::ST_IDLE: begin
            if (!sel_n_s) begin
               state_nxt = dwsp_pkg::ST_CMD;
               first_nxt = 1'b1;
               beat_nxt = 4'h0;
               ack_nxt = 1'b0;
            end
         end
         dwsp_pkg::ST_CMD: begin
            if (trail && first_r) begin
               // all four lines sampled once; unused ones read high via pull-ups
               width_nxt = decode_width(lines_s);
               sr_in_nxt = {lines_s, 4'h0};
               first_nxt = 1'b0;
            end else if (trail) begin
               sr_in_nxt = in_byte;
               if (beat_r == half_beats - 4'h1) begin
                  state_nxt = dwsp_pkg::ST_DATA;
                  beat_nxt = 4'h0;
                  cmd_nxt = cmd_field;
                  flush_nxt = cmd_field == dwsp_pkg::CMD_FLUSH;
               end else begin
                  beat_nxt = beat_r + 4'h1;
               end
            end
         end
         dwsp_pkg::ST_DATA: begin
            if (lead && beat_r == 4'h0) begin
               if (cmd_r == dwsp_pkg::CMD_WRITE) begin
                  ack_nxt = tx_space;
               end else if (cmd_r == dwsp_pkg::CMD_READ) begin
                  ack_nxt = rx_valid;
                  rx_pop = rx_valid;
                  sr_out_nxt = rx_valid ? rx_data : dwsp_pkg::BYTE_RST;
               end else begin
                  // other codes have no data path in this block and answer nak
                  ack_nxt = 1'b0;
               end
            end else if (lead) begin
               sr_out_nxt = shift_out(sr_out_r, width_r);
            end
            if (trail) begin
               sr_in_nxt = in_byte;
               if (beat_r == byte_beats(width_r) - 4'h1) begin
                  beat_nxt = 4'h0;
                  // after a nak the byte is dropped; the master must deselect
                  tx_push = (cmd_r == dwsp_pkg::CMD_WRITE) && ack_r;
               end else begin
                  beat_nxt = beat_r + 4'h1;
               end
            end
         end
         default: state_nxt = dwsp_pkg::ST_IDLE;
      endcase
      if (sel_n_s || ext_clear) begin
         state_nxt = dwsp_pkg::ST_IDLE;
      end
      if (ext_clear) begin
         rx_pop = 1'b0;
         tx_push = 1'b0;
         flush_nxt = 1'b0;
      end
   end

   // reference clock domain: i_clk_sys stands in for the internal reference
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         state_r <= dwsp_pkg::ST_IDLE;
         width_r <= dwsp_pkg::WID_1;
         cmd_r <= dwsp_pkg::CMD_WRITE;
         sr_in_r <= dwsp_pkg::BYTE_RST;
         sr_out_r <= dwsp_pkg::BYTE_RST;
         beat_r <= 4'h0;
         first_r <= 1'b0;
         ack_r <= 1'b0;
         flush_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         width_r <= width_nxt;
         cmd_r <= cmd_nxt;
         sr_in_r <= sr_in_nxt;
         sr_out_r <= sr_out_nxt;
         beat_r <= beat_nxt;
         first_r <= first_nxt;
         ack_r <= ack_nxt;
         flush_r <= flush_nxt;
      end
   end

   // pin drivers, registered
   logic [3:0] dout_r, dout_nxt, oe_n_r, oe_n_nxt;
   logic miso_r, miso_nxt;

   always_comb begin
      if (state_nxt == dwsp_pkg::ST_IDLE) begin
         dout_nxt = {3'b000, tx_space};
         oe_n_nxt = dwsp_pkg::OE_N_IDLE;
         miso_nxt = rx_valid;
      end else if (state_nxt == dwsp_pkg::ST_DATA && cmd_nxt == dwsp_pkg::CMD_READ) begin
         dout_nxt = sr_out_nxt[3:0] & lane_mask(width_nxt);
         oe_n_nxt = ~lane_mask(width_nxt);
         miso_nxt = ack_nxt;
      end else begin
         // command phase and write data: the master owns the lines
         dout_nxt = 4'h0;
         oe_n_nxt = dwsp_pkg::OE_N_OFF;
         miso_nxt = ack_nxt;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         dout_r <= dwsp_pkg::DOUT_RST;
         oe_n_r <= dwsp_pkg::OE_N_IDLE;
         miso_r <= 1'b0;
      end else begin
         dout_r <= dout_nxt;
         oe_n_r <= oe_n_nxt;
         miso_r <= miso_nxt;
      end
   end

   assign o_data_out = dout_r;
   assign o_data_oe_n = oe_n_r;
   assign o_miso = miso_r;
   assign o_flush_pulse = flush_r;

   // checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);

   sequence s_cmd_head;
      state_r == dwsp_pkg::ST_CMD && first_r && trail && !sel_n_s && !ext_clear;
   endsequence
   sequence s_cmd_last;
      state_r == dwsp_pkg::ST_CMD && !first_r && trail && !sel_n_s && !ext_clear
         && beat_r == half_beats - 4'h1;
   endsequence
   sequence s_byte_start(logic [3:0] code);
      state_r == dwsp_pkg::ST_DATA && lead && beat_r == 4'h0 && cmd_r == code
         && !sel_n_s && !ext_clear;
   endsequence

   a_idle_status: assert property (state_r == dwsp_pkg::ST_IDLE |->
      o_data_oe_n == dwsp_pkg::OE_N_IDLE && o_data_out[0] == $past(tx_space)
      && o_miso == $past(rx_valid)) else $error("idle status lines wrong");
   a_release_bus: assert property ($fell(sel_n_s) && state_r == dwsp_pkg::ST_IDLE
      && !ext_clear |=> o_data_oe_n == dwsp_pkg::OE_N_OFF
      && state_r == dwsp_pkg::ST_CMD) else $error("lines not released");
   a_width_four: assert property (s_cmd_head and lines_s[3:2] != 2'b11 |=>
      width_r == dwsp_pkg::WID_4) else $error("four line width missed");
   a_width_two: assert property (s_cmd_head and lines_s[3:1] == 3'b110 |=>
      width_r == dwsp_pkg::WID_2) else $error("two line width missed");
   a_width_one: assert property (s_cmd_head and lines_s[3:1] == 3'b111 |=>
      width_r == dwsp_pkg::WID_1) else $error("one line width missed");
   a_cmd_field: assert property (s_cmd_last |=> state_r == dwsp_pkg::ST_DATA
      && cmd_r == $past(cmd_field) && beat_r == 4'h0) else $error("command wrong");
   a_ack_write: assert property (s_byte_start(dwsp_pkg::CMD_WRITE) |=>
      o_miso == $past(tx_space)) else $error("write ack wrong");
   a_ack_read: assert property (s_byte_start(dwsp_pkg::CMD_READ) and rx_valid |->
      rx_pop ##1 o_miso ##0 o_data_oe_n == ~lane_mask(width_r))
      else $error("read ack wrong");
   a_push_last: assert property (tx_push |-> trail && ack_r && tx_space
      && beat_r == byte_beats(width_r) - 4'h1) else $error("push off boundary");
   a_hold_mode: assert property (state_r == dwsp_pkg::ST_DATA
      && $past(state_r) == dwsp_pkg::ST_DATA |-> $stable(width_r) && $stable(cmd_r))
      else $error("mode changed in selection");
   a_ext_reset: assert property (ext_clear |=> state_r == dwsp_pkg::ST_IDLE
      && !o_flush_pulse) else $error("external reset ignored");
endmodule : dwsp_port

// file: tb/dwsp_master.sv
// Purpose: link master model that drives select, link clock and data lines
// Assumes: lines are resolved outside with pull-ups; undriven reads as one
// Notes: samples right at the trailing edge, about one sys clock after the answer lands
`timescale 1ns/1ps
module dwsp_master (
   input wire logic i_cpol,
   input wire logic [3:0] i_line,
   input wire logic i_miso,
   output logic o_lclk,
   output logic o_sel_n,
   output logic [3:0] o_dout,
   output logic [3:0] o_den
);
   initial begin
      o_lclk = 1'b0;
      o_sel_n = 1'b1;
      o_dout = 4'hF;
      o_den = 4'h0;
   end

   // od leaves ones undriven so that the pull-ups supply them
   task automatic beats(input logic [7:0] v, input int nb, input int w, input bit drv,
                        input bit od, output logic [7:0] r, output logic a);
      r = 8'h00;
      a = 1'b0;
      for (int i = 0; i < nb / w; i++) begin
         o_lclk = ~i_cpol;
         o_dout = 4'hF;
         o_den = 4'h0;
         for (int k = 0; k < w; k++) begin
            o_dout[k] = v[i * w + k];
            o_den[k] = drv & ~(od & v[i * w + k]);
         end
         #40;
         if (i == 0) a = i_miso;
         for (int k = 0; k < w; k++) r[i * w + k] = i_line[k];
         o_lclk = i_cpol;
         #40;
      end
   endtask : beats

   task automatic sel();
      o_lclk = i_cpol;
      #83;
      o_sel_n = 1'b0;
      #80;
   endtask : sel

   task automatic cmd(input logic [3:0] c, input int w);
      logic [7:0] b;
      logic [7:0] r;
      logic a;
      b = {1'b1, c[0], c[1], 1'b1, c[2], 1'(w != 4), 1'(w != 2), c[3]};
      beats(b, 4, 4, 1'b1, 1'b1, r, a);
      beats(b >> 4, 4, w, 1'b1, 1'b0, r, a);
   endtask : cmd

   // abort: any partial byte is lost on the device side
   task automatic stop();
      o_den = 4'h0;
      o_sel_n = 1'b1;
      #80;
   endtask : stop
endmodule : dwsp_master

// file: tb/dwsp_port_tb.sv
// Purpose: self-checking bench for the dynamic width serial slave port
// Assumes: small buffer depth so that full and empty are reached quickly
// Notes: queues model both buffers; usb side stalls at random while draining
`timescale 1ns/1ps
module dwsp_port_tb;
   localparam int DEPTH = 4;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic ext_n = 1'b1;
   logic cpol = 1'b0;
   logic rx_valid = 1'b0;
   logic tx_ready = 1'b0;
   logic [7:0] rx_data = 8'h00;
   logic lclk, sel_n, miso, rx_ready, tx_valid, flush;
   logic [3:0] mout, men, dout, doe_n, line;
   logic [7:0] tx_data;
   int seed = 24240;
   int n_fail = 0;
   int compares = 0;
   int flushes = 0;
   logic [7:0] rxq[$];
   logic [7:0] txq[$];

   always #5 clk = ~clk;
   assign line = (~doe_n & dout) | (doe_n & men & mout) | (doe_n & ~men);

   dwsp_port #(.BUF_DEPTH(DEPTH)) i_dut (.i_clk_sys(clk), .i_reset(reset),
      .i_reset_ext_n(ext_n), .i_cpol(cpol), .i_link_clk(lclk), .i_select_n(sel_n),
      .i_data_in(line), .o_data_out(dout), .o_data_oe_n(doe_n), .o_miso(miso),
      .i_usb_rx_data(rx_data), .i_usb_rx_valid(rx_valid), .o_usb_rx_ready(rx_ready),
      .o_usb_tx_data(tx_data), .o_usb_tx_valid(tx_valid), .i_usb_tx_ready(tx_ready),
      .o_flush_pulse(flush));
   dwsp_master i_m (.i_cpol(cpol), .i_line(line), .i_miso(miso), .o_lclk(lclk),
      .o_sel_n(sel_n), .o_dout(mout), .o_den(men));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test();
      if (n_fail == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   always @(posedge clk) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         check(tx_data, (txq.size() > 0) ? txq.pop_front() : 8'hXX);
      end
      if (flush === 1'b1) flushes++;
   end

   task automatic usb_push(input logic [7:0] d);
      @(posedge clk);
      #1 rx_valid = 1'b1;
      rx_data = d;
      @(posedge clk);
      while (rx_ready !== 1'b1) @(posedge clk);
      #1 rx_valid = 1'b0;
      rxq.push_back(d);
   endtask : usb_push

   task automatic drain();
      repeat (60) begin
         @(posedge clk);
         #1 tx_ready = 1'($random(seed));
      end
      @(posedge clk);
      #1 tx_ready = 1'b0;
      check(8'(txq.size()), 8'h00);
   endtask : drain

   task automatic idle_chk();
      repeat (4) @(posedge clk);
      #1;
      check({7'h0, line[0]}, {7'h0, txq.size() < DEPTH});
      check({7'h0, miso}, {7'h0, rxq.size() > 0});
   endtask : idle_chk

   // the model decides ack from its own queues, never from the device
   task automatic frame(input logic [3:0] c, input int w, input int n);
      logic [7:0] v;
      logic [7:0] r;
      logic a;
      logic ea;
      i_m.sel();
      check({4'h0, doe_n}, 8'h0F);
      i_m.cmd(c, w);
      for (int i = 0; i < n; i++) begin
         v = 8'($random(seed));
         ea = (c == 4'h0) ? (txq.size() < DEPTH) : (c == 4'h1) ? (rxq.size() > 0) : 1'b0;
         i_m.beats(v, 8, w, c != 4'h1, 1'b0, r, a);
         check({7'h0, a}, {7'h0, ea});
         if (ea && c == 4'h0) txq.push_back(v);
         if (ea && c == 4'h1) check(r, rxq.pop_front());
         if (!ea) break;
      end
      i_m.stop();
   endtask : frame

   initial begin
      repeat (8) @(posedge clk);
      #1 reset = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check({4'h0, doe_n}, 8'h0E);
      check({6'h0, miso, tx_valid}, 8'h00);
      idle_chk();
      frame(4'h0, 4, 3);
      idle_chk();
      drain();
      frame(4'h0, 4, DEPTH + 1);
      idle_chk();
      drain();
      cpol = 1'b1;
      repeat (3) usb_push(8'($random(seed)));
      idle_chk();
      frame(4'h1, 4, 4);
      cpol = 1'b0;
      idle_chk();
      for (int c = 2; c < 16; c++) begin
         frame(4'(c), ((c & 4) == 0) ? 4 : (((c & 1) != 0) ? 1 : 2), 1);
      end
      frame(4'h4, 1, 1);
      check(8'(flushes), 8'h02);
      usb_push(8'($random(seed)));
      idle_chk();
      @(posedge clk);
      #1 ext_n = 1'b0;
      repeat (5) @(posedge clk);
      #1 ext_n = 1'b1;
      rxq.delete();
      idle_chk();
      finish_test();
   end

   initial begin
      #500000;
      n_fail++;
      finish_test();
   end
endmodule : dwsp_port_tb
